// *** arc_params.svh ***
// Purpose: constants for the read/convert host controller
// Assumes: 100 MHz clock
// Notes: times in ns, cycle counts derived from them
`ifndef ARC_PARAMS_SVH
`define ARC_PARAMS_SVH
`define ARC_CLK_PERIOD_NS 10
`define ARC_CONV_TIME_NS 2500
`define ARC_CONV_CYC ((`ARC_CONV_TIME_NS + `ARC_CLK_PERIOD_NS - 1) / `ARC_CLK_PERIOD_NS)
`define ARC_SPACING_NS 2500
`define ARC_SPACING_CYC ((`ARC_SPACING_NS + `ARC_CLK_PERIOD_NS - 1) / `ARC_CLK_PERIOD_NS)
`define ARC_ACCESS_NS 200
`define ARC_ACCESS_CYC ((`ARC_ACCESS_NS + `ARC_CLK_PERIOD_NS - 1) / `ARC_CLK_PERIOD_NS)
`define ARC_TIMEOUT_NS 10000
`define ARC_TIMEOUT_CYC ((`ARC_TIMEOUT_NS + `ARC_CLK_PERIOD_NS - 1) / `ARC_CLK_PERIOD_NS)
`define ARC_RESULT_RST 8'h00
`endif

// *** arc_pkg.sv ***
// Purpose: types for the read/convert host controller
// Assumes: 8-bit result, up to 3 address bits
// Notes: none
package arc_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_WAIT0, ST_PULSE1, ST_GAP} arc_state_e;
  typedef struct packed {
    logic mode1;
    logic [2:0] channel;
  } arc_req_s;
  typedef struct packed {
    logic [7:0] data;
    logic [2:0] channel;
    logic mode1;
    logic timeout;
  } arc_res_s;
endpackage

// *** arc_skid_buf.sv ***
// Purpose: two-entry buffer on the result path
// Assumes: single clock, synchronous reset
// Notes: in_ready is low only when both entries are taken
`timescale 1ns/1ps
`default_nettype none
module arc_skid_buf #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  wire doWr = inValid && inReady;
  wire doRd = outValid && outReady;
  assign inReady = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem_r[rdPtr_r];
  // storage, one flip-flop row per entry
  always_ff @(posedge clk) begin
    if (clkEn && doWr) begin
      mem_r[wrPtr_r] <= inData;
    end
  end
  // pointers wrap at depth so non-power-of-two depths work
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else if (clkEn) begin
      if (doWr) wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      if (doRd) rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      count_r <= count_r + (AW+1)'(doWr) - (AW+1)'(doRd);
    end
  end
endmodule // arc_skid_buf
`default_nettype wire

// *** arc_host_ctrl.sv ***
// Purpose: host controller driving a self-timed multi-channel ADC over its bus pins
// Assumes: 100 MHz clk; device pins asynchronous to clk; open-drain wait pulled up outside
// Notes: one request makes one read strobe; results leave through a two-entry buffer
// Function
// - mode follows read strobe length: held through conversion is mode 0
// - in mode 0 host keeps read low until conversion finishes
// - mode 0 host stretches its read until wait request releases
// - mode 1 host leaves at least 2.5us between reads
// - host drives select low to address the device
`timescale 1ns/1ps
`default_nettype none
`include "arc_params.svh"
module arc_host_ctrl #(
  parameter int ADDR_W = 3,
  parameter int BUF_DEPTH = 2,
  parameter int TIMEOUT_CYC = `ARC_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // user request side
  input wire logic reqValid,
  output logic reqReady,
  input wire arc_pkg::arc_req_s reqData,
  // user result side
  output logic resValid,
  input wire logic resReady,
  output arc_pkg::arc_res_s resData,
  // device pins
  output logic selectN,
  output logic readN,
  output logic [ADDR_W-1:0] channelSelect,
  input wire logic [7:0] resultBus,
  input wire logic doneN,
  input wire logic waitReqN
);
  import arc_pkg::*;
  localparam int CW = 16;
  localparam logic [CW-1:0] CONV_CYC = CW'(`ARC_CONV_CYC);
  localparam logic [CW-1:0] SPACE_CYC = CW'(`ARC_SPACING_CYC);
  localparam logic [CW-1:0] ACC_CYC = CW'(`ARC_ACCESS_CYC);
  localparam logic [CW-1:0] TO_CYC = CW'(TIMEOUT_CYC);

  arc_state_e state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [CW-1:0] gap_r;
  logic selectN_r, readN_r;
  logic [ADDR_W-1:0] chan_r;
  logic mode1_r, timeout_r;
  logic [7:0] dataCap_r;
  logic [2:0] chanCap_r;
  logic capValid_r;
  logic doneArm_r;
  logic bufInReady;
  logic [9:0] sync1_r, sync2_r;

  // two-stage synchronisers for every device pin read by logic
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_r <= 10'h3FF;
      sync2_r <= 10'h3FF;
    end else if (clkEn) begin
      sync1_r <= {resultBus, doneN, waitReqN};
      sync2_r <= sync1_r;
    end
  end
  wire [7:0] resultSync = sync2_r[9:2]; // bit 7 is the msb
  wire doneSyncN = sync2_r[1];
  wire waitSyncN = sync2_r[0];

  // a mode 0 read ends when wait releases or done falls, whichever shows first
  wire convOver = waitSyncN || (doneArm_r && !doneSyncN);
  wire cntDone = (cnt_r == '0);
  wire gapOk = (gap_r == '0);
  assign reqReady = (state_r == ST_IDLE) && gapOk;
  wire startReq = reqValid && reqReady;

  // next-state logic
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cntDone ? cnt_r : cnt_r - 1'b1;
    case (state_r)
      ST_IDLE: begin
        if (startReq) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // address settles one cycle before the strobes fall, captured on their fall
        state_nxt = mode1_r ? ST_PULSE1 : ST_WAIT0;
        cnt_nxt = mode1_r ? ACC_CYC : TO_CYC;
      end
      ST_WAIT0: begin
        // read held low through the conversion
        if ((convOver && !cntDone && cnt_r < TO_CYC - ACC_CYC) || cntDone) begin
          state_nxt = bufInReady ? ST_GAP : ST_WAIT0;
        end
      end
      ST_PULSE1: begin
        // short strobe: previous result already on the bus
        if (cntDone && bufInReady) begin
          state_nxt = ST_GAP;
        end
      end
      ST_GAP: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  wire inRead = (state_r == ST_WAIT0) || (state_r == ST_PULSE1);
  wire leaving = inRead && (state_nxt == ST_GAP);

  // done only counts once it has been seen high inside this read: a flag left low by an
  // earlier pipelined conversion stays low until the strobes rise and would end the read at once
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      doneArm_r <= 1'b0;
    end else if (clkEn) begin
      if (state_r == ST_SETUP) begin
        doneArm_r <= 1'b0;
      end else if (inRead && doneSyncN) begin
        doneArm_r <= 1'b1;
      end
    end
  end

  // state, counters and pin registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      selectN_r <= 1'b1;
      readN_r <= 1'b1;
    end else if (clkEn) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      // select and read fall together so the device starts a conversion
      selectN_r <= !(state_nxt == ST_WAIT0 || state_nxt == ST_PULSE1);
      readN_r <= !(state_nxt == ST_WAIT0 || state_nxt == ST_PULSE1);
    end
  end

  // spacing between reads covers a whole conversion, so a mode 1 read never cuts one short
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gap_r <= '0;
    end else if (clkEn) begin
      if (state_r == ST_SETUP) begin
        gap_r <= (SPACE_CYC > CONV_CYC) ? SPACE_CYC : CONV_CYC;
      end else if (!gapOk) begin
        gap_r <= gap_r - 1'b1;
      end
    end
  end

  // request capture; address n picks input n+1 on the device
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      chan_r <= '0;
      mode1_r <= 1'b0;
    end else if (clkEn && startReq) begin
      chan_r <= reqData.channel[ADDR_W-1:0];
      mode1_r <= reqData.mode1;
    end
  end

  // sample the bus while the strobes are still low; device only drives then
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dataCap_r <= `ARC_RESULT_RST;
      chanCap_r <= '0;
      timeout_r <= 1'b0;
      capValid_r <= 1'b0;
    end else if (clkEn) begin
      capValid_r <= leaving;
      if (leaving) begin
        dataCap_r <= resultSync; // both nibbles, straight binary
        chanCap_r <= 3'(chan_r);
        timeout_r <= (state_r == ST_WAIT0) && !convOver;
      end
    end
  end

  // buffer absorbs a stalled consumer; the read is held until it has room
  arc_skid_buf #(.WIDTH($bits(arc_res_s)), .DEPTH(BUF_DEPTH)) u_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .inValid(capValid_r),
    .inReady(bufInReady),
    .inData({dataCap_r, chanCap_r, mode1_r, timeout_r}),
    .outValid(resValid),
    .outReady(resReady),
    .outData(resData)
  );

  // wait request drops with select in mode 1 and is simply ignored there
  assign selectN = selectN_r;
  assign readN = readN_r;
  assign channelSelect = chan_r;
endmodule // arc_host_ctrl
`default_nettype wire

// *** arc_dev_model.sv ***
// Purpose: far-side converter model
// Assumes: host spaces its reads
// Notes: a floating bus shows ~last value
`timescale 1ns/1ps
`default_nettype none
module arc_dev_model (
  input wire logic selectN,
  input wire logic readN,
  input wire logic [2:0] channelSelect,
  input var int slowNs,
  output logic [7:0] resultBus,
  output var logic doneN = 1'b1,
  output logic waitReqN
);
  logic [7:0] outR = 8'h00;
  logic [3:0] k;
  logic busy = 1'b0;
  logic early = 1'b0;
  logic drv;
  // input n+1 holds code {n+1,~(n+1)}; slowNs stretches the track phase
  always @(negedge (selectN | readN)) begin
    k = {1'b0, channelSelect} + 4'h1;
    busy = 1'b1;
    early = 1'b1;
    #600 early = 1'b0;
    // one extra ns keeps the result and status changes off the host's clock edge
    #(401 + slowNs) outR[7:4] = k;
    #600 outR[3:0] = ~k;
    busy = 1'b0;
    doneN = 1'b0;
  end
  always @(posedge (selectN | readN)) doneN = 1'b1;
  // old word shown early: cannot tell the mode yet, so wait mode sees it too
  assign drv = !(selectN | readN) && (early || !busy);
  assign resultBus = drv ? outR : ~outR;
  assign waitReqN = selectN | !busy;
endmodule // arc_dev_model
`default_nettype wire

// *** arc_host_ctrl_sva.sv ***
// Purpose: port checks of the host controller
// Assumes: clkEn high
// Notes: bound below
`timescale 1ns/1ps
`default_nettype none
module arc_host_ctrl_sva #(
  parameter int ADDR_W = 3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire arc_pkg::arc_req_s reqData,
  input wire logic resValid,
  input wire logic resReady,
  input wire logic selectN,
  input wire logic readN,
  input wire logic [ADDR_W-1:0] channelSelect,
  input wire logic doneN,
  input wire logic waitReqN
);
  import arc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic m1R;
  logic [8:0] gapR;
  wire acc = reqValid && reqReady && clkEn;
  // mode in flight and cycles since strobes fell
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      m1R <= 1'b0;
      gapR <= 9'h1FF;
    end else begin
      if (acc) m1R <= reqData.mode1;
      if ($fell(selectN)) gapR <= 9'h000;
      else if (gapR != 9'h1FF) gapR <= gapR + 9'h001;
    end
  end
  strobe_pair_a: assert property (selectN == readN) else $error("strobes split");
  reset_idle_a: assert property (disable iff (1'b0) sys_rst |=> selectN && !resValid) else $error("not idle");
  chan_held_a: assert property (!selectN |-> $stable(channelSelect)) else $error("chan moved");
  chan_set_a: assert property (acc |=> channelSelect == $past(reqData.channel[ADDR_W-1:0])) else $error("chan");
  read_start_a: assert property (acc |-> ##[2:3] !selectN) else $error("no read");
  busy_refuse_a: assert property (!selectN |-> !reqReady) else $error("taken busy");
  read_gap_a: assert property (acc |-> gapR >= 9'd247) else $error("gap short");
  short_strobe_a: assert property ($fell(selectN) && m1R |-> ##[15:40] selectN) else $error("long");
  wait_hold_a: assert property ((!m1R && !selectN && !waitReqN && doneN) [*3] |=> !selectN) else $error("early");
  wait_end_a: assert property (!m1R && !selectN && waitReqN && resReady && !resValid |-> ##[1:6] selectN) else $error("stuck");
  m1_c: cover property ($fell(selectN) && m1R);
  m0_c: cover property ($fell(selectN) && !m1R);
  stall_c: cover property (!selectN && resValid && !resReady);
endmodule // arc_host_ctrl_sva
bind arc_host_ctrl arc_host_ctrl_sva #(.ADDR_W(ADDR_W)) arc_host_ctrl_sva_i (.clk, .sys_rst, .clkEn, .reqValid,
  .reqReady, .reqData, .resValid, .resReady, .selectN, .readN, .channelSelect, .doneN, .waitReqN);
`default_nettype wire

// *** arc_host_ctrl_bench.sv ***
// Purpose: self-checking bench of the host controller
// Assumes: model converter on the far side
// Notes: clkEn held high
`timescale 1ns/1ps
`default_nettype none
module arc_host_ctrl_bench;
  import arc_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  logic reqValid = 1'b0;
  logic resReady = 1'b1;
  arc_req_s reqData = '0;
  arc_res_s resData;
  logic reqReady, resValid, selectN, readN, doneN, waitReqN;
  logic [2:0] channelSelect;
  logic [7:0] resultBus, lastConv;
  int slowNs = 0;
  int num_errors = 0;
  int cmp_count = 0;
  arc_host_ctrl arc_host_ctrl_i (.clk, .sys_rst, .clkEn, .reqValid, .reqReady, .reqData, .resValid, .resReady,
    .resData, .selectN, .readN, .channelSelect, .resultBus, .doneN, .waitReqN);
  arc_dev_model arc_dev_model_i (.selectN, .readN, .channelSelect, .slowNs, .resultBus, .doneN, .waitReqN);
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  // bounded wait on a flag, sampled at falling edges
  task automatic wait_hi(ref logic f);
    int n = 0;
    while (f !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (f !== 1'b1) begin
      num_errors++;
      end_of_test();
    end
  endtask
  function automatic logic [7:0] conv(input logic [2:0] ch);
    logic [3:0] k = {1'b0, ch} + 4'h1;
    return {k, ~k};
  endfunction
  task automatic do_req(input logic m1, input logic [2:0] ch);
    wait_hi(reqReady);
    reqValid = 1'b1;
    reqData = '{mode1: m1, channel: ch};
    @(negedge clk);
    reqValid = 1'b0;
  endtask
  task automatic get_res(input logic [7:0] e, input logic [2:0] ch, input logic m1);
    resReady = 1'b1;
    wait_hi(resValid);
    chk("data", e, resData.data);
    chk("channel", {5'h00, ch}, {5'h00, resData.channel});
    chk("mode", {7'h00, m1}, {7'h00, resData.mode1});
    chk("timeout", 8'h00, {7'h00, resData.timeout});
    @(negedge clk);
  endtask
  // wait-mode reads on every channel
  task automatic sc_mode0();
    for (int c = 0; c < 8; c++) begin
      do_req(1'b0, 3'(c));
      lastConv = conv(3'(c));
      get_res(lastConv, 3'(c), 1'b0);
    end
  endtask
  // pipelined reads return the word before
  task automatic sc_mode1();
    logic [7:0] prev;
    for (int c = 7; c >= 0; c--) begin
      prev = lastConv;
      do_req(1'b1, 3'(c));
      lastConv = conv(3'(c));
      get_res(prev, 3'(c), 1'b1);
    end
  endtask
  // receiver stalls: third read must wait, no word lost
  task automatic sc_stall();
    resReady = 1'b0;
    for (int c = 2; c < 5; c++) do_req(1'b0, 3'(c));
    repeat (400) @(negedge clk);
    chk("held", 8'h00, {7'h00, selectN});
    for (int c = 2; c < 5; c++) get_res(conv(3'(c)), 3'(c), 1'b0);
  endtask
  // slow conversion stretches the wait
  task automatic sc_slow();
    slowNs = 2500;
    do_req(1'b0, 3'h5);
    get_res(conv(3'h5), 3'h5, 1'b0);
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    sc_mode0();
    sc_mode1();
    sc_stall();
    sc_slow();
    end_of_test();
  end
endmodule // arc_host_ctrl_bench
`default_nettype wire
